// ===== rtl/sfp_flash_if.sv
// The implementer's own choices: the strobed register port and the address map.
`include "sfp_regs.svh"

module sfp_flash_if (
  input  wire logic               ref_clk,
  input  wire logic               reset,
  input  wire logic               clk_en,
  input  wire sfp_pkg::sfp_pins_t pins,
  input  wire sfp_pkg::sfp_req_t  req,
  output logic [31:0]             rd_data_r,
  output logic [3:0]              dq_out_r,
  output logic [3:0]              dq_oe_r
);
  ////////////////////////////////////////////////////////////////////////////////
  function automatic logic is_dual(input logic [7:0] op);
    return (op == `SFP_OP_DUAL_OUT) || (op == `SFP_OP_DUAL_IO);
  endfunction : is_dual

  function automatic logic is_quad(input logic [7:0] op);
    return (op == `SFP_OP_QUAD_OUT) || (op == `SFP_OP_QUAD_IO);
  endfunction : is_quad

  function automatic logic [2:0] addr_lanes(input logic [7:0] op);
    return (op == `SFP_OP_QUAD_IO) ? 3'h4 : (op == `SFP_OP_DUAL_IO) ? 3'h2 : 3'h1;
  endfunction : addr_lanes

  function automatic logic [2:0] data_lanes(input logic [7:0] op);
    return is_quad(op) ? 3'h4 : is_dual(op) ? 3'h2 : 3'h1;
  endfunction : data_lanes

  function automatic logic [4:0] dummy_clks(input logic [7:0] op);
    return (op == `SFP_OP_DUAL_IO) ? 5'h04 : (op == `SFP_OP_QUAD_IO) ? 5'h06 : 5'h08;
  endfunction : dummy_clks

  function automatic logic [3:0] oe_mask(input logic [2:0] lanes);
    return (lanes == 3'h4) ? 4'hf : (lanes == 3'h2) ? 4'h3 : 4'h2;
  endfunction : oe_mask

  function automatic logic [23:0] shift_in(input logic [23:0] s, input logic [3:0] d,
                                           input logic [2:0] lanes);
    unique case (lanes)
      3'h2:    return {s[21:0], d[1:0]};
      3'h4:    return {s[19:0], d};
      default: return {s[22:0], d[0]};
    endcase
  endfunction : shift_in

  // Protected sector span [lo, hi); complement covers all but n sectors, anchored at the same end
  function automatic logic [25:0] region(input logic [7:0] c);
    logic [2:0]  bp;
    logic [12:0] n;
    logic [12:0] lo;
    logic [12:0] hi;
    bp = c[`SFP_CFG_BP_LSB +: 3];
    n  = (bp == 3'h0) ? 13'h0000 : (bp == 3'h7) ? `SFP_SECTORS :
         c[`SFP_CFG_SECTOR] ? (13'h0001 << (bp - 3'h1)) : (13'h0010 << (bp - 3'h1));
    if (c[`SFP_CFG_TOPBOT] ^ c[`SFP_CFG_COMPL]) begin
      lo = c[`SFP_CFG_COMPL] ? n : 13'h0000;
      hi = c[`SFP_CFG_COMPL] ? `SFP_SECTORS : n;
    end else begin
      lo = c[`SFP_CFG_COMPL] ? 13'h0000 : `SFP_SECTORS - n;
      hi = c[`SFP_CFG_COMPL] ? `SFP_SECTORS - n : `SFP_SECTORS;
    end
    return {hi, lo};
  endfunction : region

  ////////////////////////////////////////////////////////////////////////////////
  sfp_pkg::sfp_pins_t  ps;
  sfp_pkg::sfp_phase_t phase_r;
  sfp_pkg::sfp_phase_t phase_nxt;
  logic                sck_q_r;
  logic                cs_q_r;
  logic [7:0]          cfg_r;
  logic [4:0]          cnt_r;
  logic [4:0]          cnt_nxt;
  logic [23:0]         sh_r;
  logic [23:0]         sh_nxt;
  logic [7:0]          op_r;
  logic [7:0]          op_nxt;
  logic [3:0]          idx_r;
  logic [3:0]          idx_nxt;
  logic [7:0]          out_sh_r;
  logic [7:0]          out_nxt;
  logic [3:0]          dq_out_nxt;
  logic [3:0]          dq_oe_nxt;
  logic                rst_en_r;
  logic                rst_en_nxt;
  logic                soft_fire;
  logic                wsr_go;
  logic [11:0]         hw_cnt_r;
  logic [11:0]         trst_cnt_r;
  logic [11:0]         busy_cnt_r;
  logic [7:0]          mem_q;
  logic [31:0]         rd_nxt;

  // Pins are asynchronous to ref_clk; serial clock must stay well below ref_clk / 4
  sfp_sync #(
    .W       (7),
    .RST_VAL (`SFP_PIN_IDLE)
  ) u_sync (
    .ref_clk (ref_clk),
    .reset   (reset),
    .clk_en  (clk_en),
    .d       (pins),
    .q       (ps)
  );

  wire        quad_enable_bit    = cfg_r[`SFP_CFG_QUAD];
  wire        status_protect_bit = cfg_r[`SFP_CFG_STPROT];
  wire        sck_rise   = ps.sck & ~sck_q_r;
  wire        sck_fall   = ~ps.sck & sck_q_r;
  wire        cs_fall    = ~ps.cs_n & cs_q_r;
  wire        cs_rise    = ps.cs_n & ~cs_q_r;
  wire        hold_act   = ~quad_enable_bit & ~ps.dq[3] & ~ps.cs_n & ~cs_q_r; // [R12] [R14]
  wire        blocked    = status_protect_bit & ~quad_enable_bit & ~ps.dq[2]; // [R10]
  wire        hw_hold    = ~ps.rst_n && (hw_cnt_r == 12'(`SFP_TRESET_CYC)); // [R15] [R16]
  wire        init       = hw_hold | soft_fire;
  wire        quiet      = trst_cnt_r != 12'h000;
  wire        busy       = busy_cnt_r != 12'h000;
  // Hold freezes the edge detectors' effect, not the detectors themselves
  wire        rise_ok    = sck_rise & ~ps.cs_n & ~hold_act & ~cs_fall; // [R05] [R07] [R13]
  wire        fall_ok    = sck_fall & ~ps.cs_n & ~hold_act & ~cs_fall; // [R06] [R07] [R13]
  wire        cmd_done   = rise_ok && (phase_r == sfp_pkg::PH_CMD) && (cnt_r == 5'h07);
  wire [7:0]  cmd_byte   = {sh_r[6:0], ps.dq[0]}; // [R23]
  wire [23:0] addr_new   = shift_in(sh_r, ps.dq, addr_lanes(op_r));
  wire [2:0]  dlanes     = data_lanes(op_r);
  wire [7:0]  stat_byte  = {cfg_r[7:1], busy};
  wire [7:0]  src_byte   = (op_r == `SFP_OP_RD_STAT) ? stat_byte : mem_q;
  wire [7:0]  byte_cur   = (cnt_r == 5'h00) ? src_byte : out_sh_r;
  wire [4:0]  cnt_step   = cnt_r + {2'h0, dlanes};
  wire [25:0] region_w   = region(cfg_r); // [R11]
  wire        mem_wr     = req.wr && (req.addr == `SFP_MEMWR_OFS);

  sfp_mem u_mem (
    .ref_clk (ref_clk),
    .reset   (reset),
    .clk_en  (clk_en),
    .wr_en   (mem_wr),
    .wr_addr (req.wdata[11:8]),
    .wr_data (req.wdata[7:0]),
    .rd_addr (idx_r),
    .rd_data (mem_q)
  );

  ////////////////////////////////////////////////////////////////////////////////
  always_comb begin
    phase_nxt  = phase_r;
    cnt_nxt    = cnt_r;
    sh_nxt     = sh_r;
    op_nxt     = op_r;
    idx_nxt    = idx_r;
    rst_en_nxt = rst_en_r;
    out_nxt    = out_sh_r;
    dq_out_nxt = dq_out_r;
    dq_oe_nxt  = dq_oe_r;
    soft_fire  = 1'b0;
    wsr_go     = 1'b0;
    if (cs_rise) begin
      // Short or over-long frames leave nothing behind
      wsr_go    = (phase_r == sfp_pkg::PH_DIN) && (cnt_r == 5'h08); // [R24]
      phase_nxt = sfp_pkg::PH_IDLE; // [R23]
    end else if (cs_fall) begin
      phase_nxt = sfp_pkg::PH_CMD; // [R02] [R03] [R24]
      cnt_nxt   = 5'h00;
    end else if (rise_ok) begin
      unique case (phase_r)
        sfp_pkg::PH_CMD: begin
          sh_nxt  = shift_in(sh_r, ps.dq, 3'h1); // [R05]
          cnt_nxt = cnt_r + 5'h01;
          if (cmd_done) begin
            op_nxt     = cmd_byte;
            cnt_nxt    = 5'h00;
            rst_en_nxt = 1'b0;
            phase_nxt  = sfp_pkg::PH_SKIP;
            if (!quiet) begin // [R20]
              if (cmd_byte == `SFP_OP_RST_EN) begin
                rst_en_nxt = 1'b1; // [R19]
              end else if (cmd_byte == `SFP_OP_RESET) begin
                soft_fire = rst_en_r; // [R19]
              end else if (cmd_byte == `SFP_OP_WR_STAT) begin
                if (!blocked && !busy) begin // [R10]
                  phase_nxt = sfp_pkg::PH_DIN;
                end
              end else if (cmd_byte == `SFP_OP_RD_STAT) begin
                phase_nxt = sfp_pkg::PH_DOUT;
              end else if (is_dual(cmd_byte) || (is_quad(cmd_byte) && quad_enable_bit)) begin
                phase_nxt = sfp_pkg::PH_ADDR; // [R08] [R09]
              end
            end
          end
        end
        sfp_pkg::PH_ADDR: begin
          sh_nxt  = addr_new; // [R07]
          cnt_nxt = cnt_r + 5'h01;
          if (cnt_r == 5'(24 / addr_lanes(op_r)) - 5'h01) begin
            idx_nxt   = addr_new[3:0];
            cnt_nxt   = 5'h00;
            phase_nxt = sfp_pkg::PH_DUMMY;
          end
        end
        sfp_pkg::PH_DUMMY: begin
          cnt_nxt = cnt_r + 5'h01;
          if (cnt_r == dummy_clks(op_r) - 5'h01) begin
            cnt_nxt   = 5'h00;
            phase_nxt = sfp_pkg::PH_DOUT;
          end
        end
        sfp_pkg::PH_DIN: begin
          if (cnt_r != 5'h08) begin
            sh_nxt  = shift_in(sh_r, ps.dq, 3'h1); // [R05]
            cnt_nxt = cnt_r + 5'h01;
          end else begin
            phase_nxt = sfp_pkg::PH_SKIP; // [R24]
          end
        end
        default: begin
        end
      endcase
    end else if (fall_ok && (phase_r == sfp_pkg::PH_DOUT)) begin
      unique case (dlanes)
        3'h4:    dq_out_nxt = byte_cur[7:4]; // [R22]
        3'h2:    dq_out_nxt = {2'h0, byte_cur[7:6]}; // [R09]
        default: dq_out_nxt = {2'h0, byte_cur[7], 1'b0}; // [R06]
      endcase
      dq_oe_nxt = oe_mask(dlanes); // [R07] [R17]
      out_nxt   = byte_cur << dlanes;
      cnt_nxt   = cnt_step;
      if (cnt_step == 5'h08) begin
        cnt_nxt = 5'h00;
        idx_nxt = idx_r + 4'h1;
      end
    end
    if (ps.cs_n || hold_act) begin
      dq_oe_nxt = 4'h0; // [R01] [R12]
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Select history resets low so a select already low at release is not a start
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      sck_q_r  <= 1'b0;
      cs_q_r   <= 1'b0; // [R03]
      phase_r  <= sfp_pkg::PH_IDLE;
      cnt_r    <= 5'h00;
      sh_r     <= 24'h000000;
      op_r     <= 8'h00;
      idx_r    <= 4'h0;
      out_sh_r <= 8'h00;
      rst_en_r <= 1'b0;
      dq_out_r <= 4'h0;
      dq_oe_r  <= 4'h0;
    end else if (clk_en) begin
      sck_q_r  <= ps.sck;
      cs_q_r   <= ps.cs_n;
      phase_r  <= init ? sfp_pkg::PH_IDLE : phase_nxt; // [R21]
      cnt_r    <= init ? 5'h00 : cnt_nxt;
      sh_r     <= sh_nxt;
      op_r     <= op_nxt;
      idx_r    <= idx_nxt;
      out_sh_r <= out_nxt;
      rst_en_r <= ~init & rst_en_nxt;
      dq_out_r <= dq_out_nxt;
      dq_oe_r  <= init ? 4'h0 : dq_oe_nxt; // [R15]
    end
  end

  // Internal cycles count on ref_clk, so deselecting does not stop them
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      hw_cnt_r   <= 12'h000;
      trst_cnt_r <= 12'h000;
      busy_cnt_r <= 12'h000;
    end else if (clk_en) begin
      hw_cnt_r   <= ps.rst_n ? 12'h000 : hw_hold ? hw_cnt_r : hw_cnt_r + 12'h001;
      trst_cnt_r <= hw_hold ? 12'h000 : soft_fire ? 12'(`SFP_TRST_CYC) :
                    quiet ? trst_cnt_r - 12'h001 : trst_cnt_r; // [R20]
      busy_cnt_r <= init ? 12'h000 : (wsr_go ? 12'(`SFP_TW_CYC) :
                    busy ? busy_cnt_r - 12'h001 : busy_cnt_r); // [R04]
    end
  end

  // Configuration is non-volatile: neither reset path clears it
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      cfg_r <= `SFP_CFG_RST;
    end else if (clk_en) begin
      if (wsr_go && !hw_hold) begin
        cfg_r <= sh_r[7:0];
      end else if (req.wr && (req.addr == `SFP_CFG_OFS)) begin
        cfg_r <= req.wdata[7:0];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  assign rd_nxt = !req.rd ? 32'h00000000 :
    (req.addr == `SFP_CFG_OFS)    ? {24'h000000, cfg_r} :
    (req.addr == `SFP_STAT_OFS)   ? {16'h0000, op_r, 2'h0, blocked, rst_en_r, hold_act,
                                     ~ps.cs_n, quiet, busy} :
    (req.addr == `SFP_REGION_OFS) ? {3'h0, region_w[25:13], 3'h0, region_w[12:0]} :
    32'h00000000;

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      rd_data_r <= 32'h00000000;
    end else if (clk_en) begin
      rd_data_r <= rd_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  property p_deselect_hiz;
    @(posedge ref_clk) disable iff (reset) (clk_en && ps.cs_n) |=> (dq_oe_r == 4'h0);
  endproperty
  a_deselect_hiz: assert property (p_deselect_hiz) // [R01]
    else $error("data lines driven while deselected");

  property p_select_start;
    @(posedge ref_clk) disable iff (reset)
      (clk_en && cs_fall && !hw_hold) |=> (phase_r == sfp_pkg::PH_CMD) && (cnt_r == 5'h00);
  endproperty
  a_select_start: assert property (p_select_start) // [R02] [R24]
    else $error("select fall did not restart decoder");

  property p_cmd_capture;
    @(posedge ref_clk) disable iff (reset)
      (clk_en && cmd_done && !init) |=> (op_r == $past(cmd_byte));
  endproperty
  a_cmd_capture: assert property (p_cmd_capture) // [R05] [R23]
    else $error("instruction byte not captured");

  property p_busy_runs;
    @(posedge ref_clk) disable iff (reset)
      (clk_en && ps.cs_n && (busy_cnt_r > 12'h001) && !hw_hold)
        |=> (busy_cnt_r == $past(busy_cnt_r) - 12'h001);
  endproperty
  a_busy_runs: assert property (p_busy_runs) // [R04]
    else $error("internal cycle stalled while deselected");

  property p_single_out;
    @(posedge ref_clk) disable iff (reset)
      (clk_en && fall_ok && (phase_r == sfp_pkg::PH_DOUT) && (op_r == `SFP_OP_RD_STAT)
       && !hw_hold) |=> (dq_oe_r == 4'h2);
  endproperty
  a_single_out: assert property (p_single_out) // [R06]
    else $error("single read not on output line only");

  property p_dual_out;
    @(posedge ref_clk) disable iff (reset)
      (clk_en && fall_ok && (phase_r == sfp_pkg::PH_DOUT) && is_dual(op_r) && !hw_hold)
        |=> (dq_oe_r == 4'h3);
  endproperty
  a_dual_out: assert property (p_dual_out) // [R09] [R07]
    else $error("dual read not on lines 0 and 1");

  property p_quad_out;
    @(posedge ref_clk) disable iff (reset)
      (clk_en && fall_ok && (phase_r == sfp_pkg::PH_DOUT) && is_quad(op_r) && !hw_hold)
        |=> (dq_oe_r == 4'hf);
  endproperty
  a_quad_out: assert property (p_quad_out) // [R22]
    else $error("quad read not on four lines");

  property p_quad_gate;
    @(posedge ref_clk) disable iff (reset)
      (clk_en && cmd_done && is_quad(cmd_byte) && !quad_enable_bit && !hw_hold)
        |=> (phase_r == sfp_pkg::PH_SKIP);
  endproperty
  a_quad_gate: assert property (p_quad_gate) // [R08]
    else $error("quad instruction ran without quad enable");

  property p_wsr_block;
    @(posedge ref_clk) disable iff (reset)
      (clk_en && cmd_done && (cmd_byte == `SFP_OP_WR_STAT) && blocked && !hw_hold)
        |=> (phase_r == sfp_pkg::PH_SKIP);
  endproperty
  a_wsr_block: assert property (p_wsr_block) // [R10]
    else $error("status write accepted while protected");

  property p_hold_pause;
    @(posedge ref_clk) disable iff (reset)
      (clk_en && hold_act && !hw_hold)
        |=> $stable(phase_r) && $stable(cnt_r) && (dq_oe_r == 4'h0);
  endproperty
  a_hold_pause: assert property (p_hold_pause) // [R12] [R13] [R14]
    else $error("hold did not pause the interface");

  sequence s_reset_cmd;
    clk_en && cmd_done && (cmd_byte == `SFP_OP_RESET) && rst_en_r && !quiet && !hw_hold;
  endsequence
  sequence s_reset_period;
    (trst_cnt_r == 12'(`SFP_TRST_CYC)) && (phase_r == sfp_pkg::PH_IDLE)
      && (busy_cnt_r == 12'h000) && !rst_en_r;
  endsequence
  property p_soft_reset;
    @(posedge ref_clk) disable iff (reset) s_reset_cmd |=> s_reset_period;
  endproperty
  a_soft_reset: assert property (p_soft_reset) // [R19]
    else $error("software reset sequence not taken");

  property p_quiet_ignore;
    @(posedge ref_clk) disable iff (reset)
      (clk_en && cmd_done && quiet && !hw_hold)
        |=> (phase_r == sfp_pkg::PH_SKIP) && !rst_en_r;
  endproperty
  a_quiet_ignore: assert property (p_quiet_ignore) // [R20]
    else $error("instruction accepted during reset period");

  property p_hw_reset;
    @(posedge ref_clk) disable iff (reset)
      (clk_en && hw_hold) |=> (phase_r == sfp_pkg::PH_IDLE) && (busy_cnt_r == 12'h000)
        && (trst_cnt_r == 12'h000) && (dq_oe_r == 4'h0);
  endproperty
  a_hw_reset: assert property (p_hw_reset) // [R15] [R16] [R21]
    else $error("reset input did not restore power-on state");
endmodule : sfp_flash_if

// ===== rtl/sfp_regs.svh
`ifndef SFP_REGS_SVH
`define SFP_REGS_SVH
// Contract
// [R01] Select high: deselected, every data line released to high impedance.
// [R02] Select low: device selected, instructions shift in, data shifts out.
// [R03] After reset no instruction until a high-to-low select transition is seen.
// [R04] A started internal write cycle runs to completion after deselect.
// [R05] Single-line mode samples instruction, address and data on rising clock edges.
// [R06] Single-line mode drives read data on the output line at falling edges.
// [R07] Dual and quad lines capture on rising edges, drive on falling edges.
// [R08] Quad instructions work only with the quad enable bit set; pins become lines.
// [R09] Dual instructions turn serial input and output into data lines 0 and 1.
// [R10] Write-protect input low plus status protect bit blocks status writes.
// [R11] Protect bits define a protected region from one sector to whole array.
// [R12] Hold low while selected: output released, input and clock ignored.
// [R13] Hold high again: paused operation resumes where it stopped.
// [R14] Quad enable set disables hold; that pin is data line 3.
// [R15] Reset input low about one microsecond aborts all and restores power-on state.
// [R16] Reset input acts whatever the configuration or operation state.
// [R17] Both clock mode 0 and clock mode 3 are supported.
// [R18] Master keeps clock low (mode 0) or high (mode 3) at select edges.
// [R19] Reset-enable then reset instruction returns the device to power-on state.
// [R20] During the internal reset period every instruction is ignored.
// [R21] Reset input has priority over select, clock and data inputs.
// [R22] Quad instructions move data over all four data lines.
// [R23] Transaction: eight-bit instruction first, most significant first; ends at select high.
// [R24] Select falling restarts decoder; partial instruction discarded on early rise.

////////////////////////////////////////////////////////////////////////////////
`define SFP_CFG_OFS      8'h00
`define SFP_STAT_OFS     8'h04
`define SFP_REGION_OFS   8'h08
`define SFP_MEMWR_OFS    8'h0c
`define SFP_CFG_RST      8'h00
`define SFP_CFG_QUAD     0
`define SFP_CFG_STPROT   1
`define SFP_CFG_COMPL    2
`define SFP_CFG_SECTOR   3
`define SFP_CFG_TOPBOT   4
`define SFP_CFG_BP_LSB   5
`define SFP_SECTORS      13'h1000
`define SFP_PIN_IDLE     7'h1f

////////////////////////////////////////////////////////////////////////////////
`define SFP_OP_WR_STAT   8'h01
`define SFP_OP_RD_STAT   8'h05
`define SFP_OP_DUAL_OUT  8'h3b
`define SFP_OP_DUAL_IO   8'hbb
`define SFP_OP_QUAD_OUT  8'h6b
`define SFP_OP_QUAD_IO   8'heb
`define SFP_OP_RST_EN    8'h66
`define SFP_OP_RESET     8'h99

////////////////////////////////////////////////////////////////////////////////
`define SFP_CLK_MHZ      125
`define SFP_TRESET_NS    1000
`define SFP_TRESET_CYC   ((`SFP_TRESET_NS * `SFP_CLK_MHZ + 999) / 1000)
`define SFP_TRST_NS      30000
`define SFP_TRST_CYC     ((`SFP_TRST_NS * `SFP_CLK_MHZ) / 1000)
`define SFP_TW_NS        2000
`define SFP_TW_CYC       ((`SFP_TW_NS * `SFP_CLK_MHZ + 999) / 1000)
`endif

// ===== rtl/sfp_pkg.sv
package sfp_pkg;
  typedef enum logic [2:0] {
    PH_IDLE,
    PH_CMD,
    PH_ADDR,
    PH_DUMMY,
    PH_DIN,
    PH_DOUT,
    PH_SKIP
  } sfp_phase_t;

  typedef struct packed {
    logic       sck;
    logic       cs_n;
    logic       rst_n;
    logic [3:0] dq;
  } sfp_pins_t;

  typedef struct packed {
    logic [7:0]  addr;
    logic [31:0] wdata;
    logic        wr;
    logic        rd;
  } sfp_req_t;
endpackage : sfp_pkg

// ===== rtl/sfp_sync.sv
module sfp_sync #(
  parameter int           W       = 7,
  parameter logic [W-1:0] RST_VAL = '0
) (
  input  wire logic         ref_clk,
  input  wire logic         reset,
  input  wire logic         clk_en,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  logic [W-1:0] meta_r;

  for (genvar i = 0; i < W; i++) begin : g_bit
    always_ff @(posedge ref_clk or posedge reset) begin
      if (reset) begin
        meta_r[i] <= RST_VAL[i];
        q[i]      <= RST_VAL[i];
      end else if (clk_en) begin
        meta_r[i] <= d[i];
        q[i]      <= meta_r[i];
      end
    end
  end
endmodule : sfp_sync

// ===== rtl/sfp_mem.sv
module sfp_mem (
  input  wire logic       ref_clk,
  input  wire logic       reset,
  input  wire logic       clk_en,
  input  wire logic       wr_en,
  input  wire logic [3:0] wr_addr,
  input  wire logic [7:0] wr_data,
  input  wire logic [3:0] rd_addr,
  output logic      [7:0] rd_data
);
  // Contents have no reset; software loads them before reads
  logic [7:0] mem [16];

  always_ff @(posedge ref_clk) begin
    if (clk_en && wr_en) begin
      mem[wr_addr] <= wr_data;
    end
  end

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      rd_data <= 8'h00;
    end else if (clk_en) begin
      rd_data <= mem[rd_addr];
    end
  end
endmodule : sfp_mem

// ===== sim/sfp_spi_master.sv
module sfp_spi_master (
  input  wire logic          ref_clk,
  input  wire logic [3:0]    dut_out,
  input  wire logic [3:0]    dut_oe,
  output sfp_pkg::sfp_pins_t pins
);
  timeunit 1ns;
  timeprecision 1ps;
  logic       sck_r   = 1'b0;
  logic       cs_n_r  = 1'b0;
  logic       rst_n_r = 1'b1;
  logic       cpol    = 1'b0;
  logic [3:0] m_dq    = 4'hc;
  logic [3:0] m_en    = 4'hd;
  logic [3:0] res;
  // Released line shows the inverse of its last value
  assign res  = (dut_oe & dut_out) | (~dut_oe & ~(m_en ^ m_dq));
  assign pins = {sck_r, cs_n_r, rst_n_r, res};
  ////////////////////////////////////////////////////////////////////////////////
  task automatic wait_clk(input int n);
    repeat (n) @(posedge ref_clk);
  endtask : wait_clk
  task automatic sel(input logic on);
    sck_r <= cpol;
    wait_clk(5);
    cs_n_r <= ~on;
    wait_clk(5);
  endtask : sel
  // Five cycles a level: outputs need three to cross the synchronisers
  task automatic shift(input logic [31:0] v, input int w, input int n, input logic rx,
                       output logic [31:0] r);
    logic [3:0] m;
    m = (w == 4) ? 4'hf : (w == 2) ? 4'h3 : 4'h1;
    r = '0;
    for (int k = 0; k < n; k++) begin
      sck_r <= 1'b0;
      m_en  <= rx ? (m_en & ~m) : (m_en | m);
      if (!rx) begin
        m_dq <= (m_dq & ~m) | (v[31:28] >> (4 - w));
      end
      v = v << w;
      wait_clk(5);
      sck_r <= 1'b1;
      r = (r << w) | ((w == 1) ? 32'(res[1]) : 32'(res & m));
      wait_clk(5);
    end
  endtask : shift
endmodule : sfp_spi_master

// ===== sim/serial_flash_spi_pin_interface_tb.sv
module serial_flash_spi_pin_interface_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic               ref_clk = 1'b0;
  logic               reset   = 1'b1;
  logic               clk_en  = 1'b1;
  sfp_pkg::sfp_req_t  req     = '0;
  sfp_pkg::sfp_pins_t pins;
  logic [31:0]        rd_data_r, r, d;
  logic [3:0]         dq_out_r, dq_oe_r;
  int                 n_fail  = 0;
  int                 checked = 0;
  always #4 ref_clk = ~ref_clk;
  sfp_flash_if uut (.ref_clk(ref_clk), .reset(reset), .clk_en(clk_en), .pins(pins), .req(req),
    .rd_data_r(rd_data_r), .dq_out_r(dq_out_r), .dq_oe_r(dq_oe_r));
  sfp_spi_master m (.ref_clk(ref_clk), .dut_out(dq_out_r), .dut_oe(dq_oe_r), .pins(pins));
  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    checked++;
    if (g !== e) begin
      n_fail++;
      $display("Error at %0t: got %h expected %h", $time, g, e);
    end
  endtask : chk
  task automatic end_sim;
    if (n_fail == 0 && checked > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : end_sim
  task automatic reg_wr(input logic [7:0] a, input logic [31:0] v);
    req <= '{addr: a, wdata: v, wr: 1'b1, rd: 1'b0};
    @(posedge ref_clk);
    req.wr <= 1'b0;
    @(posedge ref_clk);
  endtask : reg_wr
  task automatic reg_rd(input logic [7:0] a, output logic [31:0] v);
    req <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
    @(posedge ref_clk);
    req.rd <= 1'b0;
    @(posedge ref_clk);
    v = rd_data_r;
  endtask : reg_rd
  task automatic frame(input logic [7:0] op, input logic [23:0] a, input int aw,
                       input int dmy, input int dw, input int n, output logic [31:0] q);
    m.sel(1'b1);
    m.shift({op, 24'h0}, 1, 8, 1'b0, q);
    if (aw > 0) begin
      m.shift({a, 8'h0}, aw, 24 / aw, 1'b0, q);
    end
    m.shift(32'h0, (aw > 0) ? aw : 1, dmy, 1'b0, q);
    m.shift(32'h0, dw, n, 1'b1, q);
  endtask : frame
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (6) @(posedge ref_clk);
    reset <= 1'b0;
    @(posedge ref_clk);
    reg_rd(8'h00, d);
    chk(d, 32'h0);
    frame(8'h05, 0, 0, 0, 1, 8, r);
    chk(r, 32'hff);
    m.sel(1'b0);
    reg_wr(8'h00, 32'he2);
    reg_rd(8'h40, d);
    chk(d, 32'h0);
    reg_rd(8'h08, d);
    chk(d, 32'h1000_0000);
    for (int md = 0; md < 2; md++) begin
      m.cpol = md[0];
      frame(8'h05, 0, 0, 0, 1, 8, r);
      chk(r, 32'he2);
      chk(32'(dq_oe_r), 32'h2);
      reg_rd(8'h04, d);
      chk(d & 32'hff04, 32'h0504);
      m.m_dq[3] <= 1'b0;
      m.wait_clk(6);
      chk(32'(dq_oe_r), 32'h0);
      reg_rd(8'h04, d);
      chk(d & 32'h8, 32'h8);
      m.m_dq[3] <= 1'b1;
      m.wait_clk(4);
      m.shift(32'h0, 1, 8, 1'b1, r);
      chk(r, 32'he2);
      m.sel(1'b0);
      chk(32'(dq_oe_r), 32'h0);
    end
    // Write-protect pin low with status protect set
    m.m_dq[2] <= 1'b0;
    frame(8'h01, 0, 0, 0, 1, 0, r);
    m.shift(32'h0, 1, 8, 1'b0, r);
    m.sel(1'b0);
    reg_rd(8'h04, d);
    chk(d & 32'h21, 32'h20);
    m.m_dq[2] <= 1'b1;
    frame(8'h01, 0, 0, 0, 1, 0, r);
    m.shift(32'h0, 1, 4, 1'b0, r);
    m.sel(1'b0);
    reg_rd(8'h00, d);
    chk(d, 32'he2);
    frame(8'h01, 0, 0, 0, 1, 0, r);
    m.shift(32'h5c00_0000, 1, 8, 1'b0, r);
    m.sel(1'b0);
    reg_rd(8'h04, d);
    chk(d & 32'h1, 32'h1);
    m.rst_n_r <= 1'b0;
    m.wait_clk(130);
    reg_rd(8'h04, d);
    chk(d & 32'h1, 32'h0);
    frame(8'h05, 0, 0, 0, 1, 8, r);
    chk(r, 32'hff);
    m.rst_n_r <= 1'b1;
    m.sel(1'b0);
    // Frozen clock enable must swallow the write
    clk_en <= 1'b0;
    reg_wr(8'h00, 32'hff);
    clk_en <= 1'b1;
    reg_rd(8'h00, d);
    chk(d, 32'h5c);
    reg_wr(8'h00, 32'h0);
    frame(8'h66, 0, 0, 0, 1, 0, r);
    m.sel(1'b0);
    reg_rd(8'h04, d);
    chk(d & 32'h10, 32'h10);
    frame(8'h99, 0, 0, 0, 1, 0, r);
    m.sel(1'b0);
    reg_rd(8'h04, d);
    chk(d & 32'h2, 32'h2);
    frame(8'h05, 0, 0, 0, 1, 8, r);
    chk(r, 32'hff);
    m.sel(1'b0);
    m.wait_clk(3800);
    reg_rd(8'h04, d);
    chk(d & 32'h2, 32'h0);
    frame(8'h01, 0, 0, 0, 1, 0, r);
    m.shift(32'hff80_0000, 1, 9, 1'b0, r);
    m.sel(1'b0);
    reg_rd(8'h00, d);
    chk(d, 32'h0);
    reg_wr(8'h0c, 32'h03c);
    reg_wr(8'h0c, 32'h196);
    frame(8'h6b, 0, 1, 8, 4, 2, r);
    chk(r, 32'h33);
    m.sel(1'b0);
    reg_wr(8'h00, 32'h1);
    frame(8'h6b, 0, 1, 8, 4, 4, r);
    chk(r, 32'h3c96);
    m.sel(1'b0);
    frame(8'heb, 1, 4, 6, 4, 2, r);
    chk(r, 32'h96);
    m.sel(1'b0);
    frame(8'h3b, 0, 1, 8, 2, 4, r);
    chk(r, 32'h3c);
    m.sel(1'b0);
    frame(8'hbb, 1, 2, 4, 2, 4, r);
    chk(r, 32'h96);
    m.sel(1'b0);
    end_sim();
  end
endmodule : serial_flash_spi_pin_interface_tb
